/* logic/trpe_defs.vh */
// Purpose: constants of the traffic report protocol encoder
// Assumes: included by logic/trpe_encoder.v only
// Notes: definitions only
`ifndef TRPE_DEFS_VH
`define TRPE_DEFS_VH
// Timing
`define TRPE_CLK_MHZ 125
`define TRPE_PERIOD_MS 1000
`define TRPE_PERIOD_CYC (`TRPE_PERIOD_MS * 1000 * `TRPE_CLK_MHZ)
// Register byte offsets
`define TRPE_REG_CTRL 8'h00
`define TRPE_REG_CONFIG 8'h04
`define TRPE_REG_STATUS 8'h08
// Field positions
`define TRPE_CTRL_PROTO 0
`define TRPE_CFG_SIC_LSB 0
`define TRPE_CFG_SAC_LSB 8
// Reset values
`define TRPE_CTRL_RST 1'b0
`define TRPE_SIC_RST 8'h00
`define TRPE_SAC_RST 8'h00
// Protocol selection codes
`define TRPE_PROTO_MAV 1'b0
`define TRPE_PROTO_ASX 1'b1
// Bus responses
`define TRPE_RESP_OKAY 2'h0
`define TRPE_RESP_SLVERR 2'h2
// Frame leading bytes and editions
`define TRPE_KIND_VEH 8'hF6
`define TRPE_KIND_COL 8'hF7
`define TRPE_CAT_REPORT 8'h15
`define TRPE_CAT_STATUS 8'h17
`define TRPE_ED_REPORT 8'h21
`define TRPE_ED_STATUS 8'h12
`define TRPE_GSS_TYPE 8'h02
// Beacon target identity and descriptors
`define TRPE_BEACON_SIC 8'hA1
`define TRPE_BEACON_SAC 8'h00
`define TRPE_ATP_NONICAO 3'h3
`define TRPE_ATP_ICAO 3'h0
`define TRPE_MOPS_VN 3'h2
// Frame lengths in bytes
`define TRPE_LEN_VEH 6'h27
`define TRPE_LEN_COL 6'h05
`define TRPE_LEN_ASX 6'h1E
`define TRPE_LEN_HB 6'h05
// Marker texts
`define TRPE_TXT_PRIVACY 64'h535445414C544820
`define TRPE_TXT_NOTRACK 64'h4E4F545241434B20
`endif

/* logic/trpe_encoder.v */
// Purpose: once-per-second traffic report framer, two output protocols
// Assumes: all inputs synchronous to core_clk; table written by tracker
// Notes: byte stream out with valid/ready; registers over AXI4-Lite
`timescale 1ns/1ns
`include "trpe_defs.vh"

// Overview of operation
// [RULE1] Protocol select chooses vehicle-message framing
// [RULE2] Every second, one vehicle message per aircraft
// [RULE3] Latitude, longitude signed 32-bit degrees times 1E7
// [RULE4] Altitude 32-bit millimetres, 8-bit altitude type
// [RULE5] Course centidegrees, horizontal speed cm/s, 16-bit
// [RULE6] Vertical speed cm/s, climb positive, 16-bit
// [RULE7] Callsign nine bytes, eight chars plus zero
// [RULE8] Whole seconds since last heard, 8-bit
// [RULE9] Beacon type map, first part, vehicle protocol
// [RULE10] Beacon type map, second part, vehicle protocol
// [RULE11] Beacon identifier fills the address field
// [RULE12] Vehicle message directly precedes collision message
// [RULE13] Record protocol: list every second, category 21
// [RULE14] Record protocol: category 23 heartbeat every second
// [RULE15] Identity settings usable only in record protocol
// [RULE16] Beacon targets use identity codes 161 and 0
// [RULE17] Address type 3 for non-transponder identifiers
// [RULE18] Beacon targets set version-not-supported bit
// [RULE19] Privacy or no-tracking marker text in identification
// [RULE20] Beacon type map, first part, record protocol
// [RULE21] Beacon type map, second part, record protocol
// [RULE22] Aircraft type is a 4-bit index
// [RULE23] Privacy and no-tracking flags are single bits
// [RULE24] Otherwise identification carries the normal callsign
// [RULE25] Protocol changes only at message boundaries
module trpe_encoder #(
  parameter [31:0] PERIOD_CYC = `TRPE_PERIOD_CYC
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // AXI4-Lite register slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Target table write port
  input wire tgt_wr,
  input wire tgt_clr,
  input wire [2:0] tgt_index,
  input wire [31:0] tgt_ident,
  input wire [31:0] tgt_lat,
  input wire [31:0] tgt_lon,
  input wire [31:0] tgt_alt,
  input wire [7:0] tgt_alt_type,
  input wire [15:0] tgt_heading,
  input wire [15:0] tgt_hvel,
  input wire [15:0] tgt_vvel,
  input wire [15:0] tgt_flags,
  input wire [15:0] tgt_squawk,
  input wire [63:0] tgt_callsign,
  input wire [7:0] tgt_emitter,
  input wire [3:0] tgt_actype,
  input wire tgt_beacon,
  input wire tgt_nonicao,
  input wire tgt_privacy,
  input wire tgt_notrack,
  // Collision notice request
  input wire coll_valid,
  input wire [2:0] coll_index,
  output wire coll_ready,
  // Byte stream to the serial transport
  output reg out_valid,
  output reg [7:0] out_data,
  output reg out_last,
  input wire out_ready
);

  // One-hot scheduler states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WALK = 4'h2;
  localparam [3:0] ST_LOAD = 4'h4;
  localparam [3:0] ST_SEND = 4'h8;
  // Frame kinds
  localparam [1:0] K_VEH = 2'h0;
  localparam [1:0] K_COL = 2'h1;
  localparam [1:0] K_ASX = 2'h2;
  localparam [1:0] K_HB = 2'h3;

  // Vehicle-protocol emitter category
  function [7:0] mav_emit;
    input [3:0] t;
    begin
      case (t)
        4'h1: mav_emit = 8'h09; // RULE9
        4'h2, 4'h5: mav_emit = 8'h01; // RULE9
        4'h3: mav_emit = 8'h07; // RULE9
        4'h4: mav_emit = 8'h0B; // RULE9
        4'h6, 4'h7: mav_emit = 8'h0C; // RULE9
        4'h8: mav_emit = 8'h01; // RULE10
        4'h9: mav_emit = 8'h03; // RULE10
        4'hB, 4'hC: mav_emit = 8'h0A; // RULE10
        4'hD: mav_emit = 8'h0E; // RULE10
        default: mav_emit = 8'h00; // RULE10 RULE22
      endcase
    end
  endfunction

  // Record-protocol emitter category
  function [7:0] asx_emit;
    input [3:0] t;
    begin
      case (t)
        4'h1: asx_emit = 8'h0B; // RULE20
        4'h2, 4'h8: asx_emit = 8'h01; // RULE20
        4'h3: asx_emit = 8'h0A; // RULE20
        4'h4: asx_emit = 8'h10; // RULE20
        4'h6, 4'h7: asx_emit = 8'h0F; // RULE20
        4'h5, 4'h9: asx_emit = 8'h02; // RULE21
        4'hB, 4'hC: asx_emit = 8'h0C; // RULE21
        4'hD: asx_emit = 8'h0D; // RULE21
        4'hF: asx_emit = 8'h17; // RULE21
        default: asx_emit = 8'h00; // RULE21 RULE22
      endcase
    end
  endfunction

  // Byte order reversal, 32 and 64 bits
  function [31:0] swap32;
    input [31:0] v;
    begin
      swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
    end
  endfunction

  function [63:0] swap64;
    input [63:0] v;
    begin
      swap64 = {swap32(v[31:0]), swap32(v[63:32])};
    end
  endfunction

  // Target table storage
  reg [31:0] m_ident [0:7];
  reg [31:0] m_lat [0:7];
  reg [31:0] m_lon [0:7];
  reg [31:0] m_alt [0:7];
  reg [7:0] m_alt_type [0:7];
  reg [15:0] m_heading [0:7];
  reg [15:0] m_hvel [0:7];
  reg [15:0] m_vvel [0:7];
  reg [15:0] m_flags [0:7];
  reg [15:0] m_squawk [0:7];
  reg [63:0] m_call [0:7];
  reg [7:0] m_emit [0:7];
  reg [3:0] m_type [0:7];
  reg [3:0] m_bits [0:7]; // beacon, nonicao, privacy, notrack
  reg [7:0] tgt_valid; // Entry in use
  reg [7:0] age [0:7]; // Seconds since last heard

  // Registers and control
  reg proto_sel; // Software protocol choice
  reg [7:0] sic_set; // System identification setting
  reg [7:0] sac_set; // System area setting
  reg [31:0] sec_cnt; // Report period counter
  reg sec_tick; // One-cycle pulse per period
  reg list_pend; // Periodic list owed
  reg coll_pend; // Collision notice owed
  reg [2:0] coll_idx; // Entry named by the notice
  reg [3:0] state;
  reg [1:0] kind; // Frame being sent
  reg active_proto; // Protocol of the current batch
  reg chain_col; // Collision follows this vehicle frame
  reg in_list; // Walking the periodic list
  reg [3:0] scan; // Walk position, 8 means done
  reg [2:0] cur_idx;
  reg [5:0] bidx; // Next byte of the frame
  reg [5:0] flen; // Frame length
  reg [15:0] frame_cnt; // Frames completed
  // Latched entry
  reg [31:0] c_ident, c_lat, c_lon, c_alt;
  reg [15:0] c_heading, c_hvel, c_vvel, c_flags, c_squawk;
  reg [7:0] c_alt_type, c_emit, c_age;
  reg [63:0] c_call;
  reg [3:0] c_type, c_bits;
  // AXI bookkeeping
  reg aw_got, w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // Second ticker
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_cnt <= 32'h0;
      sec_tick <= 1'b0;
    end else if (sec_cnt == PERIOD_CYC - 32'h1) begin
      sec_cnt <= 32'h0;
      sec_tick <= 1'b1; // RULE2 RULE13 RULE14
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
      sec_tick <= 1'b0;
    end
  end

  // Table write; storage needs no reset
  always @(posedge core_clk) begin
    if (tgt_wr) begin
      m_ident[tgt_index] <= tgt_ident; // RULE11
      m_lat[tgt_index] <= tgt_lat;
      m_lon[tgt_index] <= tgt_lon;
      m_alt[tgt_index] <= tgt_alt;
      m_alt_type[tgt_index] <= tgt_alt_type;
      m_heading[tgt_index] <= tgt_heading;
      m_hvel[tgt_index] <= tgt_hvel;
      m_vvel[tgt_index] <= tgt_vvel;
      m_flags[tgt_index] <= tgt_flags;
      m_squawk[tgt_index] <= tgt_squawk;
      m_call[tgt_index] <= tgt_callsign;
      m_emit[tgt_index] <= tgt_emitter;
      m_type[tgt_index] <= tgt_actype; // RULE22
      m_bits[tgt_index] <= {tgt_beacon, tgt_nonicao,
        tgt_privacy, tgt_notrack}; // RULE23
    end
  end

  // Per-entry valid flag and age; a write restarts the age
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_entry
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          tgt_valid[g] <= 1'b0;
          age[g] <= 8'h00;
        end else if (tgt_wr && tgt_index == g) begin
          tgt_valid[g] <= 1'b1;
          age[g] <= 8'h00;
        end else begin
          if (tgt_clr && tgt_index == g)
            tgt_valid[g] <= 1'b0;
          if (sec_tick && age[g] != 8'hFF)
            age[g] <= age[g] + 8'h01; // RULE8
        end
      end
    end
  endgenerate

  // AXI handshakes: one write and one read in flight
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign coll_ready = !coll_pend;

  // Register write path
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TRPE_RESP_OKAY;
      proto_sel <= `TRPE_CTRL_RST;
      sic_set <= `TRPE_SIC_RST;
      sac_set <= `TRPE_SAC_RST;
    end else begin
      // Capture address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Both halves present: commit and answer
      if (aw_got && w_got) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `TRPE_RESP_OKAY;
        case (aw_addr)
          `TRPE_REG_CTRL: begin
            if (w_strb[0])
              proto_sel <= w_data[`TRPE_CTRL_PROTO]; // RULE1
          end
          `TRPE_REG_CONFIG: begin
            // Identity settings writable only in record mode
            if (proto_sel == `TRPE_PROTO_ASX && w_strb[0])
              sic_set <= w_data[`TRPE_CFG_SIC_LSB +: 8]; // RULE15
            if (proto_sel == `TRPE_PROTO_ASX && w_strb[1])
              sac_set <= w_data[`TRPE_CFG_SAC_LSB +: 8]; // RULE15
          end
          `TRPE_REG_STATUS: ; // Read only, write ignored
          default: s_axi_bresp <= `TRPE_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register read path
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TRPE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TRPE_RESP_OKAY;
      case (s_axi_araddr)
        `TRPE_REG_CTRL: s_axi_rdata <= {31'h0, proto_sel};
        `TRPE_REG_CONFIG: begin
          // Settings hidden outside record mode
          if (proto_sel == `TRPE_PROTO_ASX)
            s_axi_rdata <= {16'h0000, sac_set, sic_set}; // RULE15
          else
            s_axi_rdata <= 32'h00000000;
        end
        `TRPE_REG_STATUS:
          s_axi_rdata <= {frame_cnt, tgt_valid, 6'h00,
                          active_proto, state != ST_IDLE};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `TRPE_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Frame contents, byte 0 in the low bits
  reg [311:0] frame_vec;
  reg [63:0] tid;
  reg [7:0] sac_b, sic_b;
  always @* begin
    frame_vec = 312'h0;
    tid = c_call; // RULE24
    if (c_bits[1])
      tid = `TRPE_TXT_PRIVACY; // RULE19
    else if (c_bits[0])
      tid = `TRPE_TXT_NOTRACK; // RULE19
    sac_b = c_bits[3] ? `TRPE_BEACON_SAC : sac_set; // RULE16
    sic_b = c_bits[3] ? `TRPE_BEACON_SIC : sic_set; // RULE16
    case (kind)
      K_VEH: begin
        // Little-endian fields in message order
        frame_vec = {c_age, // RULE8
          c_bits[3] ? mav_emit(c_type) : c_emit, // RULE9 RULE10
          8'h00, swap64(c_call), // RULE7
          c_alt_type, c_squawk, c_flags, // RULE4
          c_vvel, c_hvel, c_heading, // RULE5 RULE6
          c_alt, c_lon, c_lat, // RULE3 RULE4
          c_ident, `TRPE_KIND_VEH}; // RULE11
      end
      K_COL: frame_vec = {272'h0, c_ident, `TRPE_KIND_COL}; // RULE12
      K_ASX: begin
        // Big-endian record items
        frame_vec = {72'h0, swap64(tid), swap32(c_alt),
          swap32(c_lon), swap32(c_lat),
          c_ident[7:0], c_ident[15:8], c_ident[23:16],
          c_bits[3] ? asx_emit(c_type) : c_emit, // RULE20 RULE21
          {1'b0, c_bits[3], `TRPE_MOPS_VN, 3'h0}, // RULE18
          {(c_bits[2] ? `TRPE_ATP_NONICAO
            : `TRPE_ATP_ICAO), 5'h00}, // RULE17
          sic_b, sac_b, `TRPE_ED_REPORT, `TRPE_CAT_REPORT}; // RULE13
      end
      default: frame_vec = {272'h0, `TRPE_GSS_TYPE, sic_set, sac_set,
          `TRPE_ED_STATUS, `TRPE_CAT_STATUS}; // RULE14
    endcase
  end

  // Entry snapshot so a table write cannot tear a frame; no reset needed
  always @(posedge core_clk) begin
    if (state == ST_LOAD) begin
      c_ident <= m_ident[cur_idx];
      c_lat <= m_lat[cur_idx];
      c_lon <= m_lon[cur_idx];
      c_alt <= m_alt[cur_idx];
      c_alt_type <= m_alt_type[cur_idx];
      c_heading <= m_heading[cur_idx];
      c_hvel <= m_hvel[cur_idx];
      c_vvel <= m_vvel[cur_idx];
      c_flags <= m_flags[cur_idx];
      c_squawk <= m_squawk[cur_idx];
      c_call <= m_call[cur_idx];
      c_emit <= m_emit[cur_idx];
      c_type <= m_type[cur_idx];
      c_bits <= m_bits[cur_idx];
      c_age <= age[cur_idx];
    end
  end

  // Scheduler and byte sender
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      kind <= K_VEH;
      active_proto <= `TRPE_PROTO_MAV;
      chain_col <= 1'b0;
      in_list <= 1'b0;
      scan <= 4'h0;
      cur_idx <= 3'h0;
      bidx <= 6'h00;
      flen <= 6'h00;
      frame_cnt <= 16'h0000;
      list_pend <= 1'b0;
      coll_pend <= 1'b0;
      coll_idx <= 3'h0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
    end else begin
      // Pending owed work; a new tick wins over the clear below
      if (sec_tick)
        list_pend <= 1'b1;
      if (coll_valid && coll_ready) begin
        coll_pend <= 1'b1;
        coll_idx <= coll_index;
      end
      case (state)
        ST_IDLE: begin
          // Protocol sampled only between frames
          active_proto <= proto_sel; // RULE25
          if (coll_pend) begin
            coll_pend <= 1'b0;
            if (proto_sel == `TRPE_PROTO_MAV) begin
              cur_idx <= coll_idx;
              kind <= K_VEH;
              chain_col <= 1'b1; // RULE12
              state <= ST_LOAD;
            end
          end else if (list_pend) begin
            list_pend <= sec_tick;
            in_list <= 1'b1;
            scan <= 4'h0;
            kind <= K_VEH;
            state <= ST_WALK; // RULE2 RULE13
          end
        end
        ST_WALK: begin
          if (scan[3]) begin
            // Heartbeat closes a record-mode batch
            if (active_proto == `TRPE_PROTO_ASX && kind != K_HB) begin
              kind <= K_HB; // RULE14
              state <= ST_LOAD;
            end else begin
              in_list <= 1'b0;
              state <= ST_IDLE;
            end
          end else begin
            scan <= scan + 4'h1;
            if (tgt_valid[scan[2:0]]) begin
              cur_idx <= scan[2:0];
              kind <= (active_proto == `TRPE_PROTO_ASX) ? K_ASX
                : K_VEH; // RULE1
              state <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          case (kind)
            K_VEH: flen <= `TRPE_LEN_VEH;
            K_COL: flen <= `TRPE_LEN_COL;
            K_ASX: flen <= `TRPE_LEN_ASX;
            default: flen <= `TRPE_LEN_HB;
          endcase
          bidx <= 6'h00;
          state <= ST_SEND;
        end
        ST_SEND: begin
          if (!out_valid || out_ready) begin
            if (bidx != flen) begin
              out_valid <= 1'b1;
              out_data <= frame_vec[{bidx, 3'h0} +: 8];
              out_last <= (bidx == flen - 6'h01);
              bidx <= bidx + 6'h01;
            end else begin
              // Last byte taken: choose what follows
              out_valid <= 1'b0;
              out_last <= 1'b0;
              frame_cnt <= frame_cnt + 16'h0001;
              if (chain_col) begin
                chain_col <= 1'b0;
                kind <= K_COL; // RULE12
                state <= ST_LOAD;
              end else if (in_list) begin
                state <= ST_WALK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // trpe_encoder

/* bench/trpe_chk.sv */
// Purpose: stream and bus timing checks for trpe_encoder
// Assumes: bound to the top module ports
// Notes: helper logic tracks leading byte and length
`timescale 1ns/1ns
module trpe_chk (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Collision and stream
  input wire coll_valid,
  input wire coll_ready,
  input wire out_valid,
  input wire [7:0] out_data,
  input wire out_last,
  input wire out_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic first; // Next byte opens a frame
  logic [7:0] kind; // Leading byte of the current frame
  logic [7:0] cnt; // Bytes taken so far in the frame
  sequence s_stall; out_valid && !out_ready; endsequence
  sequence s_take; out_valid && out_ready; endsequence
  sequence s_end; out_valid && out_ready && out_last; endsequence
  // Follow frame boundaries on taken bytes
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      first <= 1'b1;
      kind <= 8'h00;
      cnt <= 8'h00;
    end else if (out_valid && out_ready) begin
      first <= out_last;
      cnt <= out_last ? 8'h00 : cnt + 8'h01;
      if (first) kind <= out_data;
    end
  end
  a_hold_stall: assert property (s_stall |=> out_valid &&
    $stable(out_data) && $stable(out_last)) else $error("byte moved");
  a_no_gap: assert property (s_take ##0 !out_last |=> out_valid)
    else $error("gap inside frame");
  a_gap_after: assert property (s_end |=> !out_valid)
    else $error("no idle after frame");
  a_frame_len: assert property (s_end |-> cnt == (kind == 8'hF6 ?
    8'h26 : kind == 8'h15 ? 8'h1D : 8'h04)) else $error("bad length");
  a_kind_known: assert property (out_valid && first |->
    out_data inside {8'hF6, 8'hF7, 8'h15, 8'h17}) else $error("bad kind");
  a_coll_prior: assert property (out_valid && first &&
    out_data == 8'hF7 |-> kind == 8'hF6) else $error("collision alone");
  a_coll_take: assert property (coll_valid && coll_ready |=>
    !coll_ready) else $error("notice not held");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no write answer");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no read answer");
endmodule // trpe_chk
bind trpe_encoder trpe_chk trpe_chk_inst (.*);

/* bench/trpe_host_sink.sv */
// Purpose: host side byte sink that reassembles frames
// Assumes: stream taken on valid and ready
// Notes: ready drops at random to stall the encoder
`timescale 1ns/1ns
module trpe_host_sink (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Byte stream
  input wire out_valid,
  input wire [7:0] out_data,
  input wire out_last,
  output logic out_ready,
  // Finished frame, right aligned
  output logic frm_done,
  output logic [319:0] frm_bits,
  output logic [7:0] frm_len
);
  logic [319:0] acc; // Bytes of the open frame
  logic [7:0] cnt; // Count of those bytes
  // Take bytes, stall one cycle in four
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ready <= 1'b0;
      frm_done <= 1'b0;
      acc <= '0;
      cnt <= 8'h00;
      frm_bits <= '0;
      frm_len <= 8'h00;
    end else begin
      out_ready <= ($urandom % 4) != 0;
      frm_done <= 1'b0;
      if (out_valid && out_ready) begin
        acc <= out_last ? '0 : {acc[311:0], out_data};
        cnt <= out_last ? 8'h00 : cnt + 8'h01;
        frm_done <= out_last;
        frm_bits <= {acc[311:0], out_data};
        frm_len <= cnt + 8'h01;
      end
    end
  end
endmodule // trpe_host_sink

/* bench/trpe_encoder_tb_top.sv */
// Purpose: self-checking bench for trpe_encoder
// Assumes: one second shortened to 2000 cycles
// Notes: whole frames compared against queued notes
`timescale 1ns/1ns
module trpe_encoder_tb_top;
  localparam int PER = 2000; // Shortened second
  logic core_clk = 1'b0, rst_b = 1'b0, p;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, coll_valid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, cfg;
  logic [3:0] s_axi_wstrb = 4'hF, tgt_actype;
  logic tgt_wr = 1'b0, tgt_clr = 1'b0, tgt_beacon, tgt_nonicao;
  logic tgt_privacy, tgt_notrack;
  logic [2:0] tgt_index, coll_index = 3'h0;
  logic [31:0] tgt_ident, tgt_lat, tgt_lon, tgt_alt;
  logic [15:0] tgt_heading, tgt_hvel, tgt_vvel, tgt_flags, tgt_squawk;
  logic [63:0] tgt_callsign;
  logic [7:0] tgt_alt_type, tgt_emitter;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, coll_ready, out_valid, out_last, out_ready, frm_done;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] out_data, frm_len;
  wire [319:0] frm_bits;
  logic [327:0] exp_q[$], fr[8], col[8]; // Notes {length, frame}
  logic [33:0] rd_q[$]; // Read notes {resp, data}
  logic [1:0] wr_q[$]; // Write response notes
  logic [127:0] mav_m = 128'h00000E0A0A0003010C0C010B07010900;
  logic [127:0] asx_m = 128'h17000D0C0C0002010F0F02100A010B00;
  int fail_count = 0, n_compared = 0, cyc = 0;
  trpe_encoder #(.PERIOD_CYC(PER)) trpe_encoder_inst (.*);
  trpe_host_sink trpe_host_sink_inst (.*);
  always #4 core_clk = ~core_clk;
  task automatic check(input string nm, input logic [327:0] s,
    input logic [327:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] sw(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  function automatic logic [15:0] h(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // Compare each result with the oldest note
  always @(posedge core_clk) begin
    if (frm_done) check("frame", {frm_len, frm_bits}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) check("read", {s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) check("bresp", s_axi_bresp, wr_q.pop_front());
  end
  // One register access; e is {resp, data}
  task automatic ax(input logic wr, input logic [7:0] a, input logic [33:0] e);
    logic ta, tw, tr, tb;
    tb = 1'b0;
    if (wr) begin
      wr_q.push_back(e[33:32]);
      s_axi_awaddr <= a;
      s_axi_wdata <= e[31:0];
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      rd_q.push_back(e);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end
    while (!tb) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      tb = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    @(posedge core_clk);
  endtask
  // Write one table entry and note its frame
  task automatic put(input int i, input logic [3:0] ty, input logic bc);
    logic [31:0] id, la, lo, al;
    logic [15:0] hd, hv, vv, fl, sq;
    logic [63:0] cs, tid;
    logic [7:0] at, em, te;
    logic pr, nt, ni;
    id = $urandom;
    la = $urandom;
    lo = $urandom;
    al = $urandom;
    {hd, hv} = $urandom;
    {vv, fl} = $urandom;
    {sq, at, te} = $urandom;
    cs = {$urandom, $urandom};
    pr = (i == 1 || i == 3);
    nt = (i == 2 || i == 3);
    ni = bc && i != 5;
    em = bc ? (p ? asx_m[8*ty +: 8] : mav_m[8*ty +: 8]) : te;
    tid = pr ? 64'h535445414C544820 : nt ? 64'h4E4F545241434B20 : cs;
    {tgt_index, tgt_ident, tgt_lat, tgt_lon, tgt_alt} <= {i[2:0], id, la, lo, al};
    {tgt_heading, tgt_hvel, tgt_vvel, tgt_flags, tgt_squawk} <= {hd, hv, vv, fl, sq};
    {tgt_alt_type, tgt_callsign, tgt_emitter, tgt_actype} <= {at, cs, te, ty};
    {tgt_beacon, tgt_nonicao, tgt_privacy, tgt_notrack} <= {bc, ni, pr, nt};
    tgt_wr <= 1'b1;
    @(posedge core_clk);
    if (p) fr[i] = {8'h1E, 80'h0, 8'h15, 8'h21, bc ? 16'h00A1 : cfg[15:0],
      ni ? 8'h60 : 8'h00, 1'b0, bc, 6'h10, em, id[23:0], la, lo, al, tid};
    else fr[i] = {8'h27, 8'h00, 8'hF6, sw(id), sw(la), sw(lo), sw(al), h(hd),
      h(hv), h(vv), h(fl), h(sq), at, cs, 8'h00, em, 8'h01};
    col[i] = {8'h05, 280'h0, 8'hF7, sw(id)};
  endtask
  // Two runs per protocol cover all sixteen aircraft types
  initial begin
    void'($urandom(32'hD937));
    for (int r = 0; r < 4; r++) begin
      p = r[1];
      rst_b <= 1'b0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      cfg = $urandom & 32'hFFFF;
      ax(1'b1, 8'h00, {33'h0, p});
      ax(1'b1, 8'h04, {2'h0, cfg});
      ax(1'b0, 8'h04, {2'h0, p ? cfg : 32'h0});
      ax(1'b0, 8'h00, {33'h0, p});
      if (r == 0) ax(1'b0, 8'h0C, {2'h2, 32'h0});
      if (r == 1) ax(1'b1, 8'h20, {2'h2, 32'h1});
      for (int i = 0; i < 8; i++) put(i, 4'(8 * r[0] + i), !(r == 2 && i == 0));
      tgt_wr <= 1'b0;
      if (r == 0) begin
        exp_q.push_back({fr[3][327:8], 8'h00});
        exp_q.push_back(col[3]);
        coll_index <= 3'h3;
        coll_valid <= 1'b1;
        @(negedge core_clk);
        while (!coll_ready) @(negedge core_clk);
        @(posedge core_clk);
        coll_valid <= 1'b0;
      end
      for (int i = 0; i < 8; i++) exp_q.push_back(fr[i]);
      if (p) exp_q.push_back({8'h05, 280'h0, 8'h17, 8'h12, cfg[15:0], 8'h02});
      while (exp_q.size() != 0) @(posedge core_clk);
      repeat (10) @(posedge core_clk);
    end
    complete_run();
  end
endmodule // trpe_encoder_tb_top
